// *** rtl/stl_torque_limit.sv ***
// What this block does
// - With overtravel stop selection 0 an active travel block stops the motor like a servo-off stop.
// - With selection 1 the motor decelerates at the emergency-stop torque and is then held in zero clamp.
// - With selection 2 the motor decelerates at the emergency-stop torque and then coasts.
// - In torque mode an overtravel stop follows the servo-off stop and ends in coast, whatever the selection.
// - The emergency-stop torque defaults to 800 and is used only with selection 1 or 2.
// - Torque is clamped to internal forward and reverse limits of 0 to 800 percent, default 800.
// - A limit above the motor's maximum torque is replaced by the motor's maximum torque.
// - The active-low limited flag is low while the torque reference exceeds the active limit.
// - The limited condition always shows in the output signal monitor, routed or not.
// - The routing field drives no output for 0 and output one, two or three for 1, 2 or 3.
// - Signals sharing an output are combined by logical OR.
// - While the forward external-limit input is low the forward external limit applies.
// - While the reverse external-limit input is low the reverse external limit applies.
// - Both external limits range 0 to 800 percent and default to 100.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module stl_torque_limit #(
    parameter int TQ_W  = stl_pkg::TQ_W,
    parameter int LIM_W = stl_pkg::LIM_W
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // avalon-mm slave
    input  wire logic [5:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    output logic                        irq,
    // drive side
    input  wire logic signed [TQ_W-1:0] torque_ref,
    input  wire logic                   motor_at_rest,
    input  wire logic                   fwd_travel_block,
    input  wire logic                   rev_travel_block,
    input  wire logic                   fwd_ext_limit_request_n,
    input  wire logic                   rev_ext_limit_request_n,
    input  wire logic [2:0]             other_status,
    // outputs to power stage
    output logic signed [TQ_W-1:0]      torque_cmd,
    output logic                        servo_off_stop_req,
    output logic                        decel_active,
    output logic                        zero_clamp,
    output logic                        coast,
    // contact outputs, low when closed
    output logic [2:0]                  status_out_n
);

    typedef struct packed {
        stl_pkg::stl_state_t           st;
        logic [1:0]                    ot_sel;
        logic                          soff_sel;
        logic                          tq_mode;
        logic [1:0]                    route;
        logic [LIM_W-1:0]              fwd_int;
        logic [LIM_W-1:0]              rev_int;
        logic [LIM_W-1:0]              fwd_ext;
        logic [LIM_W-1:0]              rev_ext;
        logic [LIM_W-1:0]              estop;
        logic [LIM_W-1:0]              motor_max;
        logic [stl_pkg::IRQ_W-1:0]     irq_stat;
        logic [stl_pkg::IRQ_W-1:0]     irq_mask;
        logic                          ack;
        logic [31:0]                   rdata;
        logic                          limited;
        logic signed [TQ_W-1:0]        tcmd;
        logic [2:0]                    out_n;
    } stl_regs_t;

    stl_regs_t s_q;
    stl_regs_t s_d;

    // smaller of two limits
    function automatic logic [LIM_W-1:0] lim_min(
        input logic [LIM_W-1:0] a,
        input logic [LIM_W-1:0] b
    );
        lim_min = (a < b) ? a : b;
    endfunction

    // limit as a signed torque value
    function automatic logic signed [TQ_W-1:0] to_tq(
        input logic [LIM_W-1:0] l
    );
        to_tq = $signed({{(TQ_W-LIM_W){1'b0}}, l});
    endfunction

    // clamp a reference between -rev and +fwd
    function automatic logic signed [TQ_W-1:0] clamp_tq(
        input logic signed [TQ_W-1:0] r,
        input logic [LIM_W-1:0]       f,
        input logic [LIM_W-1:0]       v
    );
        if (r > to_tq(f)) begin
            clamp_tq = to_tq(f);
        end else if (r < -to_tq(v)) begin
            clamp_tq = -to_tq(v);
        end else begin
            clamp_tq = r;
        end
    endfunction

    logic             fwd_ext_on;
    logic             rev_ext_on;
    logic [LIM_W-1:0] fwd_eff;
    logic [LIM_W-1:0] rev_eff;
    logic [LIM_W-1:0] est_eff;
    logic             ot_hit;
    logic             over_lim;
    logic             req;
    logic             take;
    logic [31:0]      rd_mux;

    assign fwd_ext_on = ~fwd_ext_limit_request_n;
    assign rev_ext_on = ~rev_ext_limit_request_n;

    // effective limits, capped at motor maximum
    always_comb begin
        fwd_eff = lim_min(s_q.fwd_int, s_q.motor_max);
        rev_eff = lim_min(s_q.rev_int, s_q.motor_max);
        est_eff = lim_min(s_q.estop, s_q.motor_max);
        if (fwd_ext_on) begin
            fwd_eff = lim_min(fwd_eff, s_q.fwd_ext);
        end
        if (rev_ext_on) begin
            rev_eff = lim_min(rev_eff, s_q.rev_ext);
        end
    end

    // travel block inputs, high means prohibited
    assign ot_hit = (fwd_travel_block && (torque_ref > 0))
                 || (rev_travel_block && (torque_ref < 0));

    assign over_lim = (torque_ref > to_tq(fwd_eff))
                   || (torque_ref < -to_tq(rev_eff));

    // bus handshake: one wait cycle per access
    assign req  = avs_read || avs_write;
    assign take = req && s_q.ack;

    // read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            stl_pkg::OFF_CTRL: begin
                rd_mux[stl_pkg::CTRL_OT_SEL_LSB +: 2] = s_q.ot_sel;
                rd_mux[stl_pkg::CTRL_SOFF_SEL]         = s_q.soff_sel;
                rd_mux[stl_pkg::CTRL_TQ_MODE]          = s_q.tq_mode;
                rd_mux[stl_pkg::CTRL_ROUTE_LSB +: 2]   = s_q.route;
            end
            stl_pkg::OFF_FWD_INT:   rd_mux[LIM_W-1:0] = s_q.fwd_int;
            stl_pkg::OFF_REV_INT:   rd_mux[LIM_W-1:0] = s_q.rev_int;
            stl_pkg::OFF_FWD_EXT:   rd_mux[LIM_W-1:0] = s_q.fwd_ext;
            stl_pkg::OFF_REV_EXT:   rd_mux[LIM_W-1:0] = s_q.rev_ext;
            stl_pkg::OFF_ESTOP:     rd_mux[LIM_W-1:0] = s_q.estop;
            stl_pkg::OFF_MOTOR_MAX: rd_mux[LIM_W-1:0] = s_q.motor_max;
            stl_pkg::OFF_MONITOR: begin
                rd_mux[stl_pkg::MON_LIMITED]          = s_q.limited;
                rd_mux[stl_pkg::MON_FWD_EXT]          = fwd_ext_on;
                rd_mux[stl_pkg::MON_REV_EXT]          = rev_ext_on;
                rd_mux[stl_pkg::MON_STATE_LSB +: 5]   = s_q.st;
                rd_mux[stl_pkg::MON_OUT_LSB +: 3]     = ~s_q.out_n;
            end
            stl_pkg::OFF_IRQ_STAT:
                rd_mux[stl_pkg::IRQ_W-1:0] = s_q.irq_stat;
            stl_pkg::OFF_IRQ_MASK:
                rd_mux[stl_pkg::IRQ_W-1:0] = s_q.irq_mask;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // next state of every register
    always_comb begin
        logic [stl_pkg::IRQ_W-1:0] ev;
        logic                      wr;
        ev = '0;
        wr = take && avs_write;
        s_d = s_q;
        s_d.ack = req && !s_q.ack;
        if (req && !s_q.ack) begin
            s_d.rdata = avs_read ? rd_mux : 32'h0000_0000;
        end

        // register writes, low byte lanes hold every field
        if (wr && avs_byteenable[0]) begin
            unique case (avs_address)
                stl_pkg::OFF_CTRL: begin
                    s_d.ot_sel   = avs_writedata[stl_pkg::CTRL_OT_SEL_LSB +: 2];
                    s_d.soff_sel = avs_writedata[stl_pkg::CTRL_SOFF_SEL];
                    s_d.tq_mode  = avs_writedata[stl_pkg::CTRL_TQ_MODE];
                    s_d.route    = avs_writedata[stl_pkg::CTRL_ROUTE_LSB +: 2];
                end
                stl_pkg::OFF_IRQ_MASK:
                    s_d.irq_mask = avs_writedata[stl_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        // limit registers need both low byte lanes
        if (wr && (&avs_byteenable[1:0])) begin
            unique case (avs_address)
                stl_pkg::OFF_FWD_INT:   s_d.fwd_int   = avs_writedata[LIM_W-1:0];
                stl_pkg::OFF_REV_INT:   s_d.rev_int   = avs_writedata[LIM_W-1:0];
                stl_pkg::OFF_FWD_EXT:   s_d.fwd_ext   = avs_writedata[LIM_W-1:0];
                stl_pkg::OFF_REV_EXT:   s_d.rev_ext   = avs_writedata[LIM_W-1:0];
                stl_pkg::OFF_ESTOP:     s_d.estop     = avs_writedata[LIM_W-1:0];
                stl_pkg::OFF_MOTOR_MAX: s_d.motor_max = avs_writedata[LIM_W-1:0];
                default: ;
            endcase
        end

        // overtravel stop sequence
        unique case (s_q.st)
            stl_pkg::ST_RUN: begin
                if (ot_hit) begin
                    ev[stl_pkg::EV_OT_STOP] = 1'b1;
                    if (s_q.tq_mode) begin
                        s_d.st = stl_pkg::ST_SOFF;
                    // emergency torque only for 1 or 2
                    end else if (s_q.ot_sel == stl_pkg::OT_CLAMP
                              || s_q.ot_sel == stl_pkg::OT_COAST) begin
                        s_d.st = stl_pkg::ST_DECEL;
                    end else begin
                        s_d.st = stl_pkg::ST_SOFF;
                    end
                end
            end
            stl_pkg::ST_SOFF: begin
                if (!fwd_travel_block && !rev_travel_block) begin
                    s_d.st = stl_pkg::ST_RUN;
                end else if (s_q.tq_mode && motor_at_rest) begin
                    s_d.st = stl_pkg::ST_COAST;
                    ev[stl_pkg::EV_AT_REST] = 1'b1;
                end
            end
            stl_pkg::ST_DECEL: begin
                if (motor_at_rest) begin
                    ev[stl_pkg::EV_AT_REST] = 1'b1;
                    if (s_q.ot_sel == stl_pkg::OT_CLAMP) begin
                        s_d.st = stl_pkg::ST_CLAMP;
                    end else begin
                        s_d.st = stl_pkg::ST_COAST;
                    end
                end
            end
            stl_pkg::ST_CLAMP, stl_pkg::ST_COAST: begin
                if (!fwd_travel_block && !rev_travel_block) begin
                    s_d.st = stl_pkg::ST_RUN;
                end
            end
            default: s_d.st = stl_pkg::ST_RUN;
        endcase

        // torque command per state
        unique case (s_q.st)
            stl_pkg::ST_RUN:   s_d.tcmd = clamp_tq(torque_ref, fwd_eff, rev_eff);
            stl_pkg::ST_DECEL: s_d.tcmd = clamp_tq(torque_ref, est_eff, est_eff);
            default:           s_d.tcmd = '0;
        endcase

        s_d.limited = over_lim;
        if (over_lim && !s_q.limited) begin
            ev[stl_pkg::EV_LIMITED] = 1'b1;
        end

        for (int i = 0; i < 3; i++) begin
            s_d.out_n[i] = !(other_status[i]
                          || (s_q.limited && (s_q.route == 2'(i + 1))));
        end

        // read clears status, new event wins
        if (take && avs_read && avs_address == stl_pkg::OFF_IRQ_STAT) begin
            s_d.irq_stat = ev;
        end else begin
            s_d.irq_stat = s_q.irq_stat | ev;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q           <= '0;
            s_q.st        <= stl_pkg::ST_RUN;
            s_q.ot_sel    <= stl_pkg::RST_OT_SEL;
            s_q.soff_sel  <= stl_pkg::RST_SOFF_SEL;
            s_q.route     <= stl_pkg::RST_ROUTE;
            s_q.fwd_int   <= stl_pkg::RST_INT_LIM;
            s_q.rev_int   <= stl_pkg::RST_INT_LIM;
            s_q.fwd_ext   <= stl_pkg::RST_EXT_LIM;
            s_q.rev_ext   <= stl_pkg::RST_EXT_LIM;
            s_q.estop     <= stl_pkg::RST_ESTOP;
            s_q.motor_max <= stl_pkg::RST_MOTOR_MAX;
            s_q.out_n     <= 3'h7;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign avs_waitrequest    = req && !s_q.ack;
    assign avs_readdata       = s_q.rdata;
    assign irq                = |(s_q.irq_stat & s_q.irq_mask);
    assign torque_cmd         = s_q.tcmd;
    assign servo_off_stop_req = (s_q.st == stl_pkg::ST_SOFF);
    assign decel_active       = (s_q.st == stl_pkg::ST_DECEL);
    assign zero_clamp         = (s_q.st == stl_pkg::ST_CLAMP);
    assign coast              = (s_q.st == stl_pkg::ST_COAST);
    assign status_out_n       = s_q.out_n;

    // checks
    a_sel0_soff_entry: assert property (@(posedge clk) disable iff (reset)
        (s_q.st == stl_pkg::ST_RUN && ot_hit && !s_q.tq_mode
         && s_q.ot_sel == stl_pkg::OT_AS_SOFF) |=> servo_off_stop_req)
        else $error("selection 0 did not enter servo-off stop");

    a_clamp_after_decel: assert property (@(posedge clk) disable iff (reset)
        (decel_active && motor_at_rest && s_q.ot_sel == stl_pkg::OT_CLAMP)
        |=> zero_clamp && !decel_active ##1 torque_cmd == 0)
        else $error("selection 1 did not end in zero clamp");

    a_coast_after_decel: assert property (@(posedge clk) disable iff (reset)
        (decel_active && motor_at_rest && s_q.ot_sel == stl_pkg::OT_COAST)
        |=> coast && !zero_clamp)
        else $error("selection 2 did not end in coast");

    a_torque_mode_stop: assert property (@(posedge clk) disable iff (reset)
        (s_q.tq_mode && s_q.st == stl_pkg::ST_RUN && ot_hit)
        |=> servo_off_stop_req ##0 !decel_active)
        else $error("torque mode used emergency deceleration");

    a_estop_torque_cap: assert property (@(posedge clk) disable iff (reset)
        decel_active |=> (torque_cmd <= to_tq($past(est_eff)))
                      && (torque_cmd >= -to_tq($past(est_eff))))
        else $error("deceleration torque beyond emergency limit");

    a_run_clamp: assert property (@(posedge clk) disable iff (reset)
        (s_q.st == stl_pkg::ST_RUN)
        |=> (torque_cmd <= to_tq($past(fwd_eff)))
         && (torque_cmd >= -to_tq($past(rev_eff))))
        else $error("torque command outside active limits");

    a_motor_max_cap: assert property (@(posedge clk) disable iff (reset)
        (fwd_eff <= s_q.motor_max) && (rev_eff <= s_q.motor_max))
        else $error("limit above motor maximum");

    a_limited_flag: assert property (@(posedge clk) disable iff (reset)
        over_lim |=> s_q.limited ##1
            (status_out_n[0] == !($past(other_status[0], 1)
              || $past(s_q.route, 1) == 2'h1)))
        else $error("limited flag missed or misrouted");

    a_route_none: assert property (@(posedge clk) disable iff (reset)
        (s_q.route == 2'h0) |=> (status_out_n == ~$past(other_status)))
        else $error("route zero drove an output");

    a_fwd_ext_limit: assert property (@(posedge clk) disable iff (reset)
        fwd_ext_on |-> (fwd_eff <= s_q.fwd_ext))
        else $error("forward external limit not applied");

    a_rev_ext_limit: assert property (@(posedge clk) disable iff (reset)
        rev_ext_on |-> (rev_eff <= s_q.rev_ext))
        else $error("reverse external limit not applied");

endmodule

`default_nettype wire

// *** inc/stl_pkg.sv ***
package stl_pkg;

    // widths
    localparam int LIM_W = 10;
    localparam int TQ_W  = 12;

    // register byte offsets
    localparam logic [5:0] OFF_CTRL      = 6'h00;
    localparam logic [5:0] OFF_FWD_INT   = 6'h04;
    localparam logic [5:0] OFF_REV_INT   = 6'h08;
    localparam logic [5:0] OFF_FWD_EXT   = 6'h0c;
    localparam logic [5:0] OFF_REV_EXT   = 6'h10;
    localparam logic [5:0] OFF_ESTOP     = 6'h14;
    localparam logic [5:0] OFF_MOTOR_MAX = 6'h18;
    localparam logic [5:0] OFF_MONITOR   = 6'h1c;
    localparam logic [5:0] OFF_IRQ_STAT  = 6'h20;
    localparam logic [5:0] OFF_IRQ_MASK  = 6'h24;

    // control register fields
    localparam int CTRL_OT_SEL_LSB = 0;
    localparam int CTRL_SOFF_SEL   = 2;
    localparam int CTRL_TQ_MODE    = 3;
    localparam int CTRL_ROUTE_LSB  = 4;

    // monitor register fields
    localparam int MON_LIMITED   = 0;
    localparam int MON_FWD_EXT   = 1;
    localparam int MON_REV_EXT   = 2;
    localparam int MON_STATE_LSB = 3;
    localparam int MON_OUT_LSB   = 8;

    // interrupt event bits
    localparam int IRQ_W       = 3;
    localparam int EV_LIMITED  = 0;
    localparam int EV_OT_STOP  = 1;
    localparam int EV_AT_REST  = 2;

    // reset values
    localparam logic [1:0]       RST_OT_SEL    = 2'h0;
    localparam logic             RST_SOFF_SEL  = 1'b0;
    localparam logic [1:0]       RST_ROUTE     = 2'h0;
    localparam logic [LIM_W-1:0] RST_INT_LIM   = 10'd800;
    localparam logic [LIM_W-1:0] RST_EXT_LIM   = 10'd100;
    localparam logic [LIM_W-1:0] RST_ESTOP     = 10'd800;
    localparam logic [LIM_W-1:0] RST_MOTOR_MAX = 10'd300;

    // overtravel stop selections
    localparam logic [1:0] OT_AS_SOFF  = 2'h0;
    localparam logic [1:0] OT_CLAMP    = 2'h1;
    localparam logic [1:0] OT_COAST    = 2'h2;

    // stop state machine
    typedef enum logic [4:0] {
        ST_RUN   = 5'b00001,
        ST_SOFF  = 5'b00010,
        ST_DECEL = 5'b00100,
        ST_CLAMP = 5'b01000,
        ST_COAST = 5'b10000
    } stl_state_t;

endpackage

// *** tb/stl_motor_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module stl_motor_model #(
    parameter int REST_CYC = 6
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // contact requests from the bench
    input  wire logic fwd_open,
    input  wire logic rev_open,
    // drive is braking or stopping
    input  wire logic stopping,
    // contacts and motor state
    output logic      fwd_travel_block,
    output logic      rev_travel_block,
    output logic      motor_at_rest
);
    int cnt;

    always_ff @(posedge clk) begin
        fwd_travel_block <= fwd_open & !reset;
        rev_travel_block <= rev_open & !reset;
    end

    // motor spins down a few cycles after a stop begins
    always_ff @(posedge clk) begin
        if (reset || !(fwd_open || rev_open)) begin
            cnt <= 0;
        end else if (stopping && cnt < REST_CYC) begin
            cnt <= cnt + 1;
        end
        motor_at_rest <= (cnt == REST_CYC) && !reset;
    end
endmodule
`default_nettype wire

// *** tb/stl_torque_limit_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module stl_torque_limit_bench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic signed [stl_pkg::TQ_W-1:0] torque_ref = '0;
    logic signed [stl_pkg::TQ_W-1:0] torque_cmd;
    logic at_rest, fwd_blk, rev_blk, fwd_open = 1'b0, rev_open = 1'b0;
    logic fwd_n = 1'b1, rev_n = 1'b1;
    logic [2:0] other_status = 3'h0;
    logic [2:0] status_out_n;
    logic soff, decel, zclamp, coast;
    int failures = 0;
    int num_checks = 0;

    // 20 mhz clock
    always #25 clk = ~clk;

    stl_torque_limit u_stl_torque_limit (
        .clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .torque_ref(torque_ref), .motor_at_rest(at_rest),
        .fwd_travel_block(fwd_blk), .rev_travel_block(rev_blk),
        .fwd_ext_limit_request_n(fwd_n), .rev_ext_limit_request_n(rev_n),
        .other_status(other_status), .torque_cmd(torque_cmd),
        .servo_off_stop_req(soff), .decel_active(decel),
        .zero_clamp(zclamp), .coast(coast), .status_out_n(status_out_n)
    );

    stl_motor_model u_stl_motor_model (
        .clk(clk), .reset(reset), .fwd_open(fwd_open),
        .rev_open(rev_open), .stopping(decel | soff),
        .fwd_travel_block(fwd_blk), .rev_travel_block(rev_blk),
        .motor_at_rest(at_rest)
    );

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
            failures++;
        end
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(negedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) failures++;
        @(posedge clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic tq(input int v, input int e);
        @(posedge clk);
        torque_ref <= v[11:0];
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("torque_cmd", e, torque_cmd);
    endtask

    task automatic wait_stop(input logic [3:0] e);
        int n;
        n = 0;
        while ({coast, zclamp, decel, soff} !== e && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("stop outputs", e, {coast, zclamp, decel, soff});
    endtask

    task automatic t_defaults;
        logic [5:0] a[8] = '{stl_pkg::OFF_CTRL, stl_pkg::OFF_FWD_INT,
            stl_pkg::OFF_REV_INT, stl_pkg::OFF_FWD_EXT, stl_pkg::OFF_REV_EXT,
            stl_pkg::OFF_ESTOP, stl_pkg::OFF_IRQ_MASK, 6'h28};
        int e[8] = '{0, 800, 800, 100, 100, 800, 0, 0};
        logic [31:0] q;
        wr(6'h28, 32'h5);
        foreach (a[i]) begin
            bus(1'b0, a[i], 32'h0, q);
            chk("reset value", e[i], q);
        end
        $display("test defaults done");
    endtask

    task automatic t_internal;
        logic [31:0] q;
        wr(stl_pkg::OFF_FWD_INT, 32'd200);
        wr(stl_pkg::OFF_REV_INT, 32'd100);
        tq(150, 150);
        tq(200, 200);
        bus(1'b0, stl_pkg::OFF_MONITOR, 32'h0, q);
        chk("monitor limited", 0, q[0]);
        tq(250, 200);
        bus(1'b0, stl_pkg::OFF_MONITOR, 32'h0, q);
        chk("monitor limited", 1, q[0]);
        tq(-150, -100);
        wr(stl_pkg::OFF_FWD_INT, 32'd800);
        wr(stl_pkg::OFF_REV_INT, 32'd800);
        tq(500, 300);
        tq(-500, -300);
        $display("test internal limits done");
    endtask

    task automatic t_route;
        wr(stl_pkg::OFF_FWD_INT, 32'd200);
        for (int r = 0; r < 4; r++) begin
            wr(stl_pkg::OFF_CTRL, 32'(r << 4));
            tq(250, 200);
            chk("route", (r == 0) ? 7 : 7 & ~(1 << (r - 1)), status_out_n);
            tq(100, 100);
            chk("route idle", 7, status_out_n);
        end
        wr(stl_pkg::OFF_CTRL, 32'h20);
        other_status <= 3'b001;
        tq(100, 100);
        chk("shared out", 3'b110, status_out_n);
        tq(250, 200);
        chk("shared out", 3'b100, status_out_n);
        other_status <= 3'b000;
        wr(stl_pkg::OFF_CTRL, 32'h0);
        wr(stl_pkg::OFF_FWD_INT, 32'd800);
        $display("test routing done");
    endtask

    task automatic t_ext;
        fwd_n <= 1'b0;
        tq(150, 100);
        tq(-150, -150);
        wr(stl_pkg::OFF_FWD_INT, 32'd50);
        tq(150, 50);
        fwd_n <= 1'b1;
        wr(stl_pkg::OFF_FWD_INT, 32'd800);
        tq(150, 150);
        rev_n <= 1'b0;
        tq(-150, -100);
        rev_n <= 1'b1;
        tq(-150, -150);
        $display("test external limits done");
    endtask

    task automatic t_ot(input int ctrl, input logic [3:0] f,
                        input logic [3:0] l);
        wr(stl_pkg::OFF_CTRL, 32'(ctrl));
        tq(100, 100);
        fwd_open <= 1'b1;
        wait_stop(f);
        wait_stop(l);
        // command register follows the stop state one edge later
        @(negedge clk);
        chk("stopped torque", 0, torque_cmd);
        fwd_open <= 1'b0;
        wait_stop(4'b0000);
        $display("test overtravel %0h done", ctrl);
    endtask

    task automatic t_irq;
        logic [31:0] q;
        bus(1'b0, stl_pkg::OFF_IRQ_STAT, 32'h0, q);
        wr(stl_pkg::OFF_IRQ_MASK, 32'h1);
        tq(400, 300);
        chk("irq raised", 1, irq);
        bus(1'b0, stl_pkg::OFF_IRQ_STAT, 32'h0, q);
        chk("irq status", 1, q[0]);
        @(negedge clk);
        chk("irq cleared", 0, irq);
        tq(100, 100);
        wr(stl_pkg::OFF_IRQ_MASK, 32'h0);
        tq(400, 300);
        chk("irq masked", 0, irq);
        bus(1'b0, stl_pkg::OFF_IRQ_STAT, 32'h0, q);
        chk("irq sticky", 1, q[0]);
        tq(0, 0);
        $display("test interrupt done");
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_defaults();
        t_internal();
        t_route();
        t_ext();
        t_ot(0, 4'b0001, 4'b0001);
        t_ot(1, 4'b0010, 4'b0100);
        t_ot(2, 4'b0010, 4'b1000);
        t_ot(9, 4'b0001, 4'b1000);
        t_irq();
        end_sim();
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule
`default_nettype wire
